// >>> bench/sbc_mcu_model.sv
`timescale 1ns/1ps
module sbc_mcu_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // One 8-bit frame, MSB first, clock high and low for three cycles each.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (3) @(posedge clk);
      sclk <= 1'b1;
      repeat (3) @(posedge clk);
      rx[i] = miso;
      sclk <= 1'b0;
    end
    repeat (3) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~tx[0];
    repeat (3) @(posedge clk);
  endtask : xfer
endmodule : sbc_mcu_model

// >>> bench/sbc_pin_guard_sva.sv
`timescale 1ns/1ps
module sbc_pin_guard_chk
  import sbc_pkg::*;
#(
  parameter int TXD_DIS_US = SBC_TXD_DIS_US
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic TXD,
  input wire logic RXD,
  input wire logic BUS_DOM_IN,
  input wire logic BUS_DRIVE_DOM,
  input wire logic CS_N,
  input wire logic MISO_OE,
  input wire logic RESET_MODE,
  input wire logic MAIN_UNDERVOLT,
  input wire logic RST_OUT_N,
  input wire logic MAIN_OT_WARN,
  input wire logic OT_WARN_FLAG,
  input wire logic MAIN_OT_SHUT,
  input wire logic MAIN_REG_ON,
  input wire logic WD_EXPIRED,
  input wire logic WATCHDOG_FAULT_OUT_N,
  input wire logic BATT_LOW,
  input wire logic BATTERY_FAIL_FLAG,
  input wire logic HS_OVERTEMP,
  input wire logic HIGH_SIDE_SWITCH,
  input wire logic BUS_FAILED,
  input wire logic INT_N
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  // Counts how long the transmit input has been held dominant.
  logic [19:0] low_q;
  logic [19:0] low_d;
  assign low_d = TXD ? 20'h0_0000 : low_q + 20'h0_0001;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      low_q <= 20'h0_0000;
    end else begin
      low_q <= low_d;
    end
  end

  property p_tx;
    BUS_DRIVE_DOM |-> !$past(TXD);
  endproperty
  a_tx: assert property (p_tx) else $error("bus driven with transmit recessive");
  property p_rx;
    !RXD |-> $past(BUS_DOM_IN);
  endproperty
  a_rx: assert property (p_rx) else $error("receive low with bus recessive");
  property p_guard;
    low_q > (TXD_DIS_US + 2) * SBC_TICK_CYC |-> !BUS_DRIVE_DOM;
  endproperty
  a_guard: assert property (p_guard) else $error("transmitter not blocked");
  property p_rst;
    $past(RST_N) |-> RST_OUT_N == !($past(RESET_MODE) || $past(MAIN_UNDERVOLT));
  endproperty
  a_rst: assert property (p_rst) else $error("reset output wrong");
  property p_otw;
    $past(RST_N) |-> OT_WARN_FLAG == $past(MAIN_OT_WARN);
  endproperty
  a_otw: assert property (p_otw) else $error("warning flag wrong");
  property p_reg;
    $past(RST_N) |-> MAIN_REG_ON == !$past(MAIN_OT_SHUT);
  endproperty
  a_reg: assert property (p_reg) else $error("regulator enable wrong");
  property p_wd;
    $past(RST_N) |-> WATCHDOG_FAULT_OUT_N == !$past(WD_EXPIRED);
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog fault output wrong");
  property p_bat;
    $past(RST_N) && $past(BATT_LOW) |-> BATTERY_FAIL_FLAG;
  endproperty
  a_bat: assert property (p_bat) else $error("battery flag not set");
  property p_hs;
    $past(RST_N) && $past(HS_OVERTEMP) |-> !HIGH_SIDE_SWITCH;
  endproperty
  a_hs: assert property (p_hs) else $error("switch on while overheated");
  property p_oe;
    MISO_OE == !CS_N;
  endproperty
  a_oe: assert property (p_oe) else $error("serial output enable wrong");

  c_fail: cover property ($rose(BUS_FAILED));
  c_int: cover property ($fell(INT_N));
  c_guard: cover property ($fell(BUS_DRIVE_DOM) && !TXD);
endmodule : sbc_pin_guard_chk

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench
  import sbc_pkg::*;
;
  localparam int TXD_US = 20;
  localparam int TK = SBC_TICK_CYC;
  logic REF_CLK, RST_N, TXD, RXD, BUS_DOM_IN, CANH_IN, CANL_IN, BUS_DRIVE_DOM, BUS_FAILED;
  logic SCLK, CS_N, MOSI, MISO, MISO_OE, CMD_READY, HOLD_CMD, INT_N, RESET_MODE, MAIN_UNDERVOLT;
  logic RST_OUT_N, MAIN_OT_WARN, MAIN_OT_SHUT, OT_WARN_FLAG, MAIN_REG_ON, WD_EXPIRED;
  logic WATCHDOG_FAULT_OUT_N, LEVEL_INPUT_A, LEVEL_INPUT_B, WAKE_EVENT, BATT_LOW, BATTERY_FAIL_FLAG;
  logic SEC_SUPPLY_LOW, SEC_SUPPLY_OVERLOAD, HS_OVERTEMP, HIGH_SIDE_SWITCH;
  logic [1:0] MODE;
  logic [7:0] r;
  int n_fail;
  int comparisons;
  int n;

  sbc_pin_guard #(.TXD_DIS_US(TXD_US), .HS_PERIOD_US(400)) u_sbc_pin_guard (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .TXD(TXD), .RXD(RXD), .BUS_DOM_IN(BUS_DOM_IN),
    .CANH_IN(CANH_IN), .CANL_IN(CANL_IN), .BUS_DRIVE_DOM(BUS_DRIVE_DOM), .BUS_FAILED(BUS_FAILED),
    .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO), .MISO_OE(MISO_OE), .CMD_READY(CMD_READY),
    .HOLD_CMD(HOLD_CMD), .INT_N(INT_N), .RESET_MODE(RESET_MODE), .MAIN_UNDERVOLT(MAIN_UNDERVOLT),
    .RST_OUT_N(RST_OUT_N), .MAIN_OT_WARN(MAIN_OT_WARN), .MAIN_OT_SHUT(MAIN_OT_SHUT),
    .OT_WARN_FLAG(OT_WARN_FLAG), .MAIN_REG_ON(MAIN_REG_ON), .WD_EXPIRED(WD_EXPIRED),
    .WATCHDOG_FAULT_OUT_N(WATCHDOG_FAULT_OUT_N), .LEVEL_INPUT_A(LEVEL_INPUT_A),
    .LEVEL_INPUT_B(LEVEL_INPUT_B), .WAKE_EVENT(WAKE_EVENT), .BATT_LOW(BATT_LOW),
    .BATTERY_FAIL_FLAG(BATTERY_FAIL_FLAG), .SEC_SUPPLY_LOW(SEC_SUPPLY_LOW),
    .SEC_SUPPLY_OVERLOAD(SEC_SUPPLY_OVERLOAD), .HS_OVERTEMP(HS_OVERTEMP),
    .HIGH_SIDE_SWITCH(HIGH_SIDE_SWITCH), .MODE(MODE)
  );
  sbc_mcu_model u_sbc_mcu_model (.clk(REF_CLK), .sclk(SCLK), .cs_n(CS_N), .mosi(MOSI), .miso(MISO));

  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end

  task automatic results;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic chkb(input string s, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", s, e, g);
    end
  endtask : chkb
  task automatic cyc(input int k);
    repeat (k) @(posedge REF_CLK);
    #1;
  endtask : cyc
  task automatic waitv(input logic on_int, input logic v);
    n = 0;
    while ((on_int ? INT_N : WAKE_EVENT) !== v) begin
      cyc(1);
      n++;
      if (n > 4000) begin
        n_fail++;
        results();
      end
    end
  endtask : waitv
  task automatic wr(input logic [2:0] a, input logic [3:0] d);
    u_sbc_mcu_model.xfer({a, 1'b1, d}, r);
    cyc(4);
  endtask : wr
  // A read answers in the following frame, so a harmless read trails it.
  task automatic rdc(input string s, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_sbc_mcu_model.xfer({a, 1'b0, 4'h0}, r);
    u_sbc_mcu_model.xfer({SBC_ADR_IEN, 1'b0, 4'h0}, v);
    comparisons++;
    if (v !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, e, v);
    end
    cyc(2);
  endtask : rdc
  task automatic txd(input logic v, input int k);
    @(posedge REF_CLK);
    TXD <= v;
    cyc(k);
  endtask : txd
  task automatic edges(input logic [1:0] p, input int k);
    repeat (k) begin
      @(posedge REF_CLK);
      {CANH_IN, CANL_IN} <= p;
      cyc(4);
      @(posedge REF_CLK);
      {CANH_IN, CANL_IN} <= 2'b00;
      cyc(4);
    end
  endtask : edges

  task automatic t_reset;
    chkb("rxd", 1'b1, RXD);
    chkb("intn", 1'b1, INT_N);
    chkb("hs", 1'b0, HIGH_SIDE_SWITCH);
    chkb("rstn", 1'b1, RST_OUT_N);
    rdc("mode", SBC_ADR_MODE, 8'h00);
    rdc("can", SBC_ADR_CAN, 8'h23);
    rdc("ien", SBC_ADR_IEN, 8'h40);
  endtask : t_reset
  task automatic t_txrx;
    @(posedge REF_CLK);
    BUS_DOM_IN <= 1'b1;
    txd(1'b0, 3);
    chkb("drive", 1'b1, BUS_DRIVE_DOM);
    chkb("rxd", 1'b0, RXD);
    @(posedge REF_CLK);
    BUS_DOM_IN <= 1'b0;
    txd(1'b1, 3);
    chkb("drive", 1'b0, BUS_DRIVE_DOM);
    chkb("rxd", 1'b1, RXD);
    wr(SBC_ADR_CAN, 4'h2);
    txd(1'b0, 3);
    chkb("txoff", 1'b0, BUS_DRIVE_DOM);
    txd(1'b1, 1);
    wr(SBC_ADR_CAN, 4'h3);
  endtask : t_txrx
  task automatic t_guard;
    txd(1'b0, (TXD_US - 2) * TK);
    chkb("guard", 1'b1, BUS_DRIVE_DOM);
    cyc(4 * TK);
    chkb("guard", 1'b0, BUS_DRIVE_DOM);
    txd(1'b1, 8 * TK);
    txd(1'b0, 3);
    chkb("early", 1'b0, BUS_DRIVE_DOM);
    txd(1'b1, 12 * TK);
    txd(1'b0, 3);
    chkb("again", 1'b1, BUS_DRIVE_DOM);
    txd(1'b1, 3);
  endtask : t_guard
  task automatic t_bus;
    wr(SBC_ADR_IEN, 4'h1);
    edges(2'b10, 2);
    chkb("nofail", 1'b0, BUS_FAILED);
    edges(2'b10, 1);
    chkb("fail", 1'b1, BUS_FAILED);
    chkb("intn", 1'b0, INT_N);
    rdc("canf", SBC_ADR_CAN, 8'h2B);
    rdc("iflag", SBC_ADR_IFLAG, 8'h61);
    chkb("intclr", 1'b1, INT_N);
    edges(2'b01, 2);
    chkb("stillf", 1'b1, BUS_FAILED);
    edges(2'b01, 1);
    chkb("recov", 1'b0, BUS_FAILED);
    rdc("iflag", SBC_ADR_IFLAG, 8'h61);
    wr(SBC_ADR_IEN, 4'h0);
  endtask : t_bus
  task automatic t_fifo;
    @(posedge REF_CLK);
    HOLD_CMD <= 1'b1;
    for (int i = 0; i < SBC_FIFO_DEPTH; i++) begin
      wr(SBC_ADR_IEN, (i == SBC_FIFO_DEPTH - 1) ? 4'h5 : 4'h0);
    end
    chkb("full", 1'b0, CMD_READY);
    wr(SBC_ADR_IEN, 4'hA);
    @(posedge REF_CLK);
    HOLD_CMD <= 1'b0;
    cyc(40);
    chkb("ready", 1'b1, CMD_READY);
    rdc("drain", SBC_ADR_IEN, 8'h45);
    wr(SBC_ADR_IEN, 4'h0);
  endtask : t_fifo
  task automatic t_flags;
    @(posedge REF_CLK);
    {MAIN_OT_WARN, MAIN_OT_SHUT, WD_EXPIRED, RESET_MODE, BATT_LOW} <= 5'h1F;
    cyc(3);
    chkb("otw", 1'b1, OT_WARN_FLAG);
    chkb("regon", 1'b0, MAIN_REG_ON);
    chkb("watchdog_fault_out", 1'b0, WATCHDOG_FAULT_OUT_N);
    chkb("rstm", 1'b0, RST_OUT_N);
    @(posedge REF_CLK);
    {MAIN_OT_SHUT, WD_EXPIRED, RESET_MODE, BATT_LOW, MAIN_UNDERVOLT} <= 5'h01;
    cyc(3);
    chkb("rstuv", 1'b0, RST_OUT_N);
    chkb("bat", 1'b1, BATTERY_FAIL_FLAG);
    rdc("modeb", SBC_ADR_MODE, 8'h0C);
    chkb("batclr", 1'b0, BATTERY_FAIL_FLAG);
    @(posedge REF_CLK);
    {MAIN_UNDERVOLT, MAIN_OT_WARN} <= 2'b00;
  endtask : t_flags
  task automatic t_io;
    @(posedge REF_CLK);
    LEVEL_INPUT_A <= 1'b1;
    cyc(3);
    rdc("lvla", SBC_ADR_IO, 8'h81);
    @(posedge REF_CLK);
    {LEVEL_INPUT_A, LEVEL_INPUT_B, SEC_SUPPLY_OVERLOAD} <= 3'b011;
    cyc(3);
    rdc("ovl", SBC_ADR_IO, 8'h8A);
    @(posedge REF_CLK);
    {LEVEL_INPUT_B, SEC_SUPPLY_OVERLOAD, SEC_SUPPLY_LOW} <= 3'b001;
    cyc(3);
    rdc("v2low", SBC_ADR_IO, 8'h88);
    @(posedge REF_CLK);
    SEC_SUPPLY_LOW <= 1'b0;
    wr(SBC_ADR_IO, 4'h1);
    chkb("hson", 1'b1, HIGH_SIDE_SWITCH);
    wr(SBC_ADR_MODE, 4'h1);
    chkb("stby", 1'b1, MODE == SBC_MODE_STANDBY);
    chkb("hsstby", 1'b1, HIGH_SIDE_SWITCH);
    wr(SBC_ADR_MODE, 4'h0);
    @(posedge REF_CLK);
    HS_OVERTEMP <= 1'b1;
    cyc(3);
    chkb("hsot", 1'b0, HIGH_SIDE_SWITCH);
    @(posedge REF_CLK);
    HS_OVERTEMP <= 1'b0;
    rdc("hsrec", SBC_ADR_IO, 8'h84);
    wr(SBC_ADR_IO, 4'h0);
  endtask : t_io
  task automatic t_wake;
    wr(SBC_ADR_IEN, 4'h8);
    wr(SBC_ADR_MODE, 4'h2);
    chkb("stop", 1'b1, MODE == SBC_MODE_STOP);
    @(posedge REF_CLK);
    LEVEL_INPUT_A <= 1'b1;
    waitv(1'b0, 1'b1);
    chkb("wake", 1'b1, WAKE_EVENT);
    waitv(1'b1, 1'b0);
    waitv(1'b1, 1'b1);
    chkb("pulse", 1'b1, n >= 9 * TK && n <= 11 * TK);
    cyc(10);
    chkb("nohold", 1'b1, INT_N);
    wr(SBC_ADR_IO, 4'h1);
    wr(SBC_ADR_MODE, 4'h3);
    chkb("held", 1'b0, INT_N);
    chkb("hsslp", 1'b0, HIGH_SIDE_SWITCH);
    @(posedge REF_CLK);
    LEVEL_INPUT_B <= 1'b1;
    waitv(1'b0, 1'b1);
    chkb("wakeslp", 1'b1, WAKE_EVENT);
  endtask : t_wake

  initial begin
    n_fail = 0;
    comparisons = 0;
    RST_N = 1'b0;
    TXD = 1'b1;
    {BUS_DOM_IN, CANH_IN, CANL_IN, HOLD_CMD, RESET_MODE, MAIN_UNDERVOLT, MAIN_OT_WARN} = '0;
    {MAIN_OT_SHUT, WD_EXPIRED, LEVEL_INPUT_A, LEVEL_INPUT_B, BATT_LOW} = '0;
    {SEC_SUPPLY_LOW, SEC_SUPPLY_OVERLOAD, HS_OVERTEMP} = '0;
    repeat (12) @(posedge REF_CLK);
    RST_N <= 1'b1;
    cyc(3);
    t_reset();
    t_txrx();
    t_guard();
    t_bus();
    t_fifo();
    t_flags();
    t_io();
    t_wake();
    results();
  end
endmodule : testbench

bind sbc_pin_guard sbc_pin_guard_chk #(.TXD_DIS_US(TXD_DIS_US)) u_sbc_pin_guard_chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .TXD(TXD), .RXD(RXD), .BUS_DOM_IN(BUS_DOM_IN),
  .BUS_DRIVE_DOM(BUS_DRIVE_DOM), .CS_N(CS_N), .MISO_OE(MISO_OE), .RESET_MODE(RESET_MODE),
  .MAIN_UNDERVOLT(MAIN_UNDERVOLT), .RST_OUT_N(RST_OUT_N), .MAIN_OT_WARN(MAIN_OT_WARN),
  .OT_WARN_FLAG(OT_WARN_FLAG), .MAIN_OT_SHUT(MAIN_OT_SHUT), .MAIN_REG_ON(MAIN_REG_ON),
  .WD_EXPIRED(WD_EXPIRED), .WATCHDOG_FAULT_OUT_N(WATCHDOG_FAULT_OUT_N), .BATT_LOW(BATT_LOW),
  .BATTERY_FAIL_FLAG(BATTERY_FAIL_FLAG), .HS_OVERTEMP(HS_OVERTEMP),
  .HIGH_SIDE_SWITCH(HIGH_SIDE_SWITCH), .BUS_FAILED(BUS_FAILED), .INT_N(INT_N)
);

// >>> rtl/sbc_pin_guard.sv
`timescale 1ns/1ps
module sbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire empty = (wp_q == rp_q);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_q + (AW+1)'(push);
      rp_q <= rp_q + (AW+1)'(pop);
    end
  end
endmodule : sbc_fifo

// What this block does
// - Normal mode: drive bus dominant while transmit input low, recessive while high; recessive in other modes.
// - Receive output low while bus dominant, high while recessive.
// - Normal mode: flag bus failure when line edge count difference reaches three.
// - Normal mode: declare recovery when the failed line again shows three edges.
// - Continuous dominant transmit input disables transmitter after 0.75 to 4 ms.
// - Disabled transmitter re-enables after transmit input recessive 10 to 60 us.
// - Set main regulator overtemperature pre-warning flag above the warning level.
// - Switch main regulator off at its shutdown temperature level.
// - Hold reset output low while main regulator is undervoltage.
// - Reset output low in reset mode or undervoltage, high otherwise.
// - Enabled interrupt holds interrupt output low outside stop mode until software reads the flag register.
// - In stop mode a wake-up gives one 10 us low interrupt pulse.
// - Watchdog fault output low when software watchdog was not serviced.
// - Both level input states are readable over the serial interface.
// - Level input activity in sleep or stop mode is a wake-up event.
// - Set battery fail flag whenever battery supply is low, in every mode.
// - Report secondary supply low, overloaded or shorted in the io status register.
// - Shut the high-side switch on overtemperature and record it in io status.
// - High-side switch from serial register; cyclic in sleep, held in normal or standby.
// - Serial port answers only while chip select is low.
// - Serial transfers are 8 bits, commands on MOSI, status on MISO.
// - Host programs the bus transceiver state with serial commands.
// - Reading the mode control register clears the battery fail flag.
// - All timing derives from one internal tick generator.
module sbc_pin_guard
  import sbc_pkg::*;
#(
  parameter int TXD_DIS_US = SBC_TXD_DIS_US,
  parameter int HS_PERIOD_US = SBC_HS_PERIOD_US
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic TXD,
  output logic RXD,
  input wire logic BUS_DOM_IN,
  input wire logic CANH_IN,
  input wire logic CANL_IN,
  output logic BUS_DRIVE_DOM,
  output logic BUS_FAILED,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic MOSI,
  output logic MISO,
  output logic MISO_OE,
  output logic CMD_READY,
  input wire logic HOLD_CMD,
  output logic INT_N,
  input wire logic RESET_MODE,
  input wire logic MAIN_UNDERVOLT,
  output logic RST_OUT_N,
  input wire logic MAIN_OT_WARN,
  input wire logic MAIN_OT_SHUT,
  output logic OT_WARN_FLAG,
  output logic MAIN_REG_ON,
  input wire logic WD_EXPIRED,
  output logic WATCHDOG_FAULT_OUT_N,
  input wire logic LEVEL_INPUT_A,
  input wire logic LEVEL_INPUT_B,
  output logic WAKE_EVENT,
  input wire logic BATT_LOW,
  output logic BATTERY_FAIL_FLAG,
  input wire logic SEC_SUPPLY_LOW,
  input wire logic SEC_SUPPLY_OVERLOAD,
  input wire logic HS_OVERTEMP,
  output logic HIGH_SIDE_SWITCH,
  output logic [1:0] MODE
);
  // Microsecond tick shared by every timer.
  logic [7:0] div_q;
  wire tick = (div_q == 8'(SBC_TICK_CYC - 1));
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) div_q <= '0;
    else div_q <= tick ? '0 : div_q + 8'h01;
  end

  // Register state written or read over the serial port.
  sbc_mode_type mode_q;
  logic [1:0] can_q;
  logic [3:0] ien_q;
  logic [1:0] hs_q;
  logic [3:0] pend_q;
  logic bat_q;
  logic otw_q;
  logic hs_ot_q;
  logic [7:0] resp_q;

  // Serial shifter, clocked by sampled edges of the serial clock.
  logic sclk_q;
  logic cs_n_q;
  logic [7:0] rx_sh_q;
  logic [7:0] tx_sh_q;
  logic [3:0] bit_q;
  wire sel = !CS_N;
  wire sclk_rise = sel && SCLK && !sclk_q;
  wire sclk_fall = sel && !SCLK && sclk_q;
  wire cs_fall = cs_n_q && !CS_N;
  wire byte_done = sclk_rise && (bit_q == SBC_BIT_LAST);
  wire [7:0] rx_byte = {rx_sh_q[6:0], MOSI};

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      rx_sh_q <= '0;
      tx_sh_q <= '0;
      bit_q <= '0;
    end else begin
      sclk_q <= SCLK;
      cs_n_q <= CS_N;
      if (cs_fall) begin
        tx_sh_q <= resp_q;
        bit_q <= '0;
      end else if (sclk_rise) begin
        rx_sh_q <= rx_byte;
        bit_q <= byte_done ? '0 : bit_q + 4'h1;
      end else if (sclk_fall) begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end
  assign MISO = tx_sh_q[SBC_BITS-1];
  assign MISO_OE = sel;

  // Command queue between the shifter and the decoder.
  // A byte that completes while the queue is full is dropped, so the host must watch CMD_READY.
  sbc_cmd_type cmd;
  logic cmd_valid;
  wire cmd_take = cmd_valid && !HOLD_CMD;
  sbc_fifo #(
    .WIDTH(SBC_BITS),
    .DEPTH(SBC_FIFO_DEPTH)
  ) u_fifo (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .in_valid(byte_done),
    .in_ready(CMD_READY),
    .in_data(rx_byte),
    .out_valid(cmd_valid),
    .out_ready(!HOLD_CMD),
    .out_data(cmd)
  );

  wire wr_cmd = cmd_take && cmd.wr;
  wire rd_cmd = cmd_take && !cmd.wr;
  wire rd_mode = rd_cmd && (cmd.addr == SBC_ADR_MODE);
  wire rd_flag = rd_cmd && (cmd.addr == SBC_ADR_IFLAG);
  wire low_power = (mode_q == SBC_MODE_STOP) || (mode_q == SBC_MODE_SLEEP);
  wire normal = (mode_q == SBC_MODE_NORMAL);
  wire v2_fault = SEC_SUPPLY_LOW || SEC_SUPPLY_OVERLOAD;
  wire [3:0] io_stat = {v2_fault, hs_ot_q, LEVEL_INPUT_B, LEVEL_INPUT_A};
  wire [3:0] mode_stat = {bat_q, otw_q, mode_q};
  wire [3:0] can_stat = {BUS_FAILED, 1'b0, can_q};
  wire [3:0] rd_data = (cmd.addr == SBC_ADR_MODE) ? mode_stat :
                       (cmd.addr == SBC_ADR_CAN) ? can_stat :
                       (cmd.addr == SBC_ADR_IEN) ? ien_q :
                       (cmd.addr == SBC_ADR_IFLAG) ? pend_q :
                       (cmd.addr == SBC_ADR_IO) ? io_stat : 4'h0;

  // Level inputs: any change in a low-power mode wakes the device.
  logic [1:0] lvl_q;
  wire [1:0] lvl = {LEVEL_INPUT_B, LEVEL_INPUT_A};
  wire wake = low_power && (lvl != lvl_q);

  // Bus failure detection by edge count difference.
  // Recovery counts rising edges on the line that lagged behind when the failure was found.
  sbc_bus_type bus_q;
  logic canh_q;
  logic canl_q;
  logic signed [3:0] diff_q;
  logic [3:0] rec_q;
  logic weak_l_q;
  wire eh = CANH_IN && !canh_q;
  wire el = CANL_IN && !canl_q;
  wire signed [3:0] diff_d = diff_q + 4'(eh) - 4'(el);
  wire hit = (diff_d == $signed(SBC_EDGE_LIMIT)) || (diff_d == -$signed(SBC_EDGE_LIMIT));
  wire weak_edge = weak_l_q ? el : eh;
  wire recover = (rec_q + 4'(weak_edge)) == SBC_EDGE_LIMIT;
  wire bus_evt = normal && ((bus_q == SBC_BUS_OK && hit) || (bus_q == SBC_BUS_FAIL && recover));

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      bus_q <= SBC_BUS_OK;
      canh_q <= 1'b0;
      canl_q <= 1'b0;
      diff_q <= '0;
      rec_q <= '0;
      weak_l_q <= 1'b0;
    end else begin
      canh_q <= CANH_IN;
      canl_q <= CANL_IN;
      if (normal) begin
        unique case (bus_q)
          SBC_BUS_OK: begin
            diff_q <= hit ? '0 : diff_d;
            if (hit) begin
              bus_q <= SBC_BUS_FAIL;
              weak_l_q <= (diff_d > 0);
              rec_q <= '0;
            end
          end
          SBC_BUS_FAIL: begin
            rec_q <= recover ? '0 : rec_q + 4'(weak_edge);
            if (recover) bus_q <= SBC_BUS_OK;
          end
        endcase
      end
    end
  end
  assign BUS_FAILED = (bus_q == SBC_BUS_FAIL);

  // Permanent dominant guard on the transmit input.
  // Only an unbroken stretch at one level advances the counter.
  sbc_txg_type txg_q;
  logic [12:0] txc_q;
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      txg_q <= SBC_TX_ON;
      txc_q <= '0;
    end else begin
      unique case (txg_q)
        SBC_TX_ON: begin
          if (TXD) txc_q <= '0;
          else if (tick) txc_q <= txc_q + 13'h0001;
          if (!TXD && tick && txc_q == 13'(TXD_DIS_US - 1)) begin
            txg_q <= SBC_TX_BLOCKED;
            txc_q <= '0;
          end
        end
        SBC_TX_BLOCKED: begin
          if (!TXD) txc_q <= '0;
          else if (tick) txc_q <= txc_q + 13'h0001;
          if (TXD && tick && txc_q == 13'(SBC_TXD_EN_US - 1)) begin
            txg_q <= SBC_TX_ON;
            txc_q <= '0;
          end
        end
      endcase
    end
  end

  // Transceiver pins.
  wire tx_allowed = normal && can_q[SBC_CAN_TX_EN] && (txg_q == SBC_TX_ON);
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      BUS_DRIVE_DOM <= 1'b0;
      RXD <= 1'b1;
    end else begin
      BUS_DRIVE_DOM <= tx_allowed && !TXD;
      RXD <= !(can_q[SBC_CAN_RX_EN] && BUS_DOM_IN);
    end
  end

  // Stop-mode wake pulse and high-side cyclic timer.
  logic [3:0] wpc_q;
  logic [15:0] hsc_q;
  wire pulse_on = (wpc_q != 4'h0);
  wire hs_cyc_on = (hsc_q < 16'(SBC_HS_ON_US));
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      wpc_q <= '0;
      hsc_q <= '0;
    end else begin
      if (wake && mode_q == SBC_MODE_STOP) wpc_q <= 4'(SBC_WAKE_PULSE_US);
      else if (tick && pulse_on) wpc_q <= wpc_q - 4'h1;
      if (tick) hsc_q <= (hsc_q == 16'(HS_PERIOD_US - 1)) ? '0 : hsc_q + 16'h0001;
    end
  end

  // Register writes, sticky flags and interrupt pending bits.
  wire [3:0] irq_set = {wake, MAIN_OT_WARN && !otw_q, BATT_LOW && !bat_q, bus_evt};
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      mode_q <= SBC_MODE_NORMAL;
      can_q <= SBC_CAN_RESET;
      ien_q <= SBC_IEN_RESET;
      hs_q <= '0;
      pend_q <= '0;
      bat_q <= 1'b0;
      otw_q <= 1'b0;
      hs_ot_q <= 1'b0;
      lvl_q <= '0;
      resp_q <= '0;
    end else begin
      lvl_q <= lvl;
      if (wr_cmd) begin
        unique case (cmd.addr)
          SBC_ADR_MODE: mode_q <= sbc_mode_type'(cmd.data[1:0]);
          SBC_ADR_CAN: can_q <= cmd.data[1:0];
          SBC_ADR_IEN: ien_q <= cmd.data;
          SBC_ADR_IO: hs_q <= cmd.data[1:0];
          default: ;
        endcase
      end
      if (rd_cmd) resp_q <= {cmd.addr, 1'b0, rd_data};
      pend_q <= (pend_q & ~({4{rd_flag}})) | irq_set;
      bat_q <= BATT_LOW || (bat_q && !rd_mode);
      otw_q <= MAIN_OT_WARN;
      hs_ot_q <= HS_OVERTEMP || (hs_ot_q && !(rd_cmd && cmd.addr == SBC_ADR_IO));
    end
  end

  // Pin outputs.
  wire hs_req = (mode_q == SBC_MODE_SLEEP) ? (hs_q[SBC_HS_CYCLIC] && hs_cyc_on) :
                (mode_q == SBC_MODE_STOP) ? 1'b0 : hs_q[SBC_HS_ON];
  wire irq_level = |(pend_q & ien_q) && (mode_q != SBC_MODE_STOP);
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      INT_N <= 1'b1;
      RST_OUT_N <= 1'b0;
      MAIN_REG_ON <= 1'b1;
      WATCHDOG_FAULT_OUT_N <= 1'b1;
      HIGH_SIDE_SWITCH <= 1'b0;
      WAKE_EVENT <= 1'b0;
    end else begin
      INT_N <= !(irq_level || pulse_on);
      RST_OUT_N <= !(RESET_MODE || MAIN_UNDERVOLT);
      MAIN_REG_ON <= !MAIN_OT_SHUT;
      WATCHDOG_FAULT_OUT_N <= !WD_EXPIRED;
      HIGH_SIDE_SWITCH <= hs_req && !HS_OVERTEMP;
      WAKE_EVENT <= wake;
    end
  end
  assign OT_WARN_FLAG = otw_q;
  assign BATTERY_FAIL_FLAG = bat_q;
  assign MODE = mode_q;
endmodule : sbc_pin_guard

// >>> rtl/sbc_pkg.sv
package sbc_pkg;
  // One internal time base: every timer counts microsecond ticks.
  localparam int SBC_CLK_NS = 5;
  localparam int SBC_TICK_NS = 1000;
  localparam int SBC_TICK_CYC = SBC_TICK_NS / SBC_CLK_NS;
  localparam real SBC_TXD_DIS_MS = 0.75;
  localparam int SBC_TXD_DIS_US = int'(SBC_TXD_DIS_MS * 1000.0);
  localparam int SBC_TXD_EN_US = 10;
  localparam int SBC_WAKE_PULSE_US = 10;
  localparam int SBC_HS_PERIOD_US = 20000;
  localparam int SBC_HS_ON_US = 200;
  localparam logic [3:0] SBC_EDGE_LIMIT = 4'h3;
  localparam int SBC_BITS = 8;
  localparam int SBC_FIFO_DEPTH = 16;
  localparam logic [3:0] SBC_BIT_LAST = 4'h7;

  localparam logic [2:0] SBC_ADR_MODE = 3'h0;
  localparam logic [2:0] SBC_ADR_CAN = 3'h1;
  localparam logic [2:0] SBC_ADR_IEN = 3'h2;
  localparam logic [2:0] SBC_ADR_IFLAG = 3'h3;
  localparam logic [2:0] SBC_ADR_IO = 3'h4;

  localparam int SBC_CAN_TX_EN = 0;
  localparam int SBC_CAN_RX_EN = 1;
  localparam int SBC_HS_ON = 0;
  localparam int SBC_HS_CYCLIC = 1;
  localparam int SBC_IRQ_BUS = 0;
  localparam int SBC_IRQ_BAT = 1;
  localparam int SBC_IRQ_OTW = 2;
  localparam int SBC_IRQ_WAKE = 3;

  localparam logic [1:0] SBC_CAN_RESET = 2'h3;
  localparam logic [3:0] SBC_IEN_RESET = 4'h0;

  typedef enum logic [1:0] {
    SBC_MODE_NORMAL = 2'h0,
    SBC_MODE_STANDBY = 2'h1,
    SBC_MODE_STOP = 2'h2,
    SBC_MODE_SLEEP = 2'h3
  } sbc_mode_type;

  typedef enum logic [1:0] {
    SBC_TX_ON = 2'b01,
    SBC_TX_BLOCKED = 2'b10
  } sbc_txg_type;

  typedef enum logic [1:0] {
    SBC_BUS_OK = 2'b01,
    SBC_BUS_FAIL = 2'b10
  } sbc_bus_type;

  typedef struct packed {
    logic [2:0] addr;
    logic wr;
    logic [3:0] data;
  } sbc_cmd_type;
endpackage : sbc_pkg
